/* sdram_bank_pkg.sv */
// Constants, types and timing counts for the four-bank SDRAM core.
// Assumes one 200 MHz clock; all times are rounded to whole cycles here.
// What this block does
// - Chip select high is an inhibit; no new command, banks carry on.
// - Select low with strobes all high is a no-op; operations continue.
// - Commands count only with clock enable high twice, after self-refresh exit time.
// - An idle bank puts no limit on commands to other banks.
// - Other banks accept ACTIVE, READ, WRITE, PRECHARGE while one activates, opens or precharges.
// - A bank is idle only once precharged and the precharge period is over.
// - A bank is row-active once opened, delay elapsed, and no burst running.
// - An auto-precharge access holds its state until its precharge period ends.
// - Burst terminate acts only on the bank owning the running burst.
// - Every allowed READ or WRITE works with or without auto precharge.
// - Read interrupting read switches output data one read latency later.
// - Write interrupts plain read on registration; mask two clocks before.
// - Write interrupts auto-precharge read on registration; mask two clocks before.
// - Read interrupts write on registration; last write word one clock before.
// - Write interrupts plain write on registration; last word one clock before.
// - ACTIVE or PRECHARGE to another bank leaves a running burst untouched.
// - An interrupted auto-precharge burst still starts its own precharge.
// - Interrupted auto-precharge read starts precharge when the new command registers.
// - Interrupted auto-precharge write precharges after write recovery time.
package sdram_bank_pkg;
   localparam int NUM_BANKS = 4;
   localparam int BANK_W = 2;
   localparam int ADDR_W = 13;
   localparam int AUTO_PRE_BIT = 10;
   localparam int BL_LSB = 0;
   localparam int CL_LSB = 4;
   localparam int TIMER_W = 5;
   localparam int CLK_PERIOD_NS = 5;
   localparam int PRECHARGE_PERIOD_NS = 19;
   localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 19;
   localparam int WRITE_RECOVERY_TIME_NS = 15;
   localparam int SELF_REFRESH_EXIT_TIME_NS = 80;
   localparam int AUTO_REFRESH_PERIOD_NS = 80;
   localparam logic [TIMER_W-1:0] PRECHARGE_CYCLES =
      TIMER_W'((PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] ACT_TO_COL_CYCLES =
      TIMER_W'((ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] WRITE_RECOVERY_CYCLES =
      TIMER_W'((WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] SELF_REFRESH_EXIT_CYCLES =
      TIMER_W'((SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] AUTO_REFRESH_CYCLES =
      TIMER_W'((AUTO_REFRESH_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] RESET_BL_CODE = 3'h0;
   localparam logic [2:0] RESET_READ_LATENCY = 3'h3;
   localparam logic [2:0] BL_CODE_FULL = 3'h7;

   typedef enum logic [3:0] {
      BANK_IDLE = 4'h0,
      BANK_ACTIVATING = 4'h1,
      BANK_ACTIVE = 4'h2,
      BANK_READ = 4'h3,
      BANK_WRITE = 4'h4,
      BANK_READ_AP = 4'h5,
      BANK_WRITE_AP = 4'h6,
      BANK_PRECHARGING = 4'h7,
      BANK_AP_RECOVERY = 4'h8,
      BANK_AP_PRECHARGE = 4'h9
   } bank_state_type;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD = 3'h2,
      CMD_WR = 3'h3,
      CMD_BST = 3'h4,
      CMD_PRE = 3'h5,
      CMD_AR = 3'h6,
      CMD_LMR = 3'h7
   } cmd_kind_type;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BANK_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
   } sdram_cmd_type;
endpackage

/* sdram_bank_tracker.sv */
// One bank's state machine with its own timer and open row.
// Assumes the top only passes commands that this bank may take now.
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_tracker
   import sdram_bank_pkg::*;
#(
   parameter int ROW_W = 13
)
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_activate,
   input wire logic i_column,
   input wire logic i_write,
   input wire logic i_auto_pre,
   input wire logic i_precharge,
   input wire logic i_burst_stop,
   input wire logic [ROW_W-1:0] i_row,
   output bank_state_type o_state,
   output logic [ROW_W-1:0] o_row
);
   logic [TIMER_W-1:0] timer;
   bank_state_type col_state;

   if (PRECHARGE_CYCLES < 2 || ACT_TO_COL_CYCLES < 2 || WRITE_RECOVERY_CYCLES < 2)
   begin : g_check
      $error("bank timer counts must be at least two cycles");
   end

   always_comb
   begin
      col_state = i_write ? (i_auto_pre ? BANK_WRITE_AP : BANK_WRITE)
                          : (i_auto_pre ? BANK_READ_AP : BANK_READ);
   end

   // ---------------------------------------------------------------
   // State and timer
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_state <= BANK_IDLE;
         timer <= '0;
      end
      else
      begin
         timer <= (timer != '0) ? timer - 1'b1 : timer;
         case (o_state)
            BANK_IDLE:
               if (i_activate)
               begin
                  o_state <= BANK_ACTIVATING;
                  timer <= ACT_TO_COL_CYCLES - 2'h2;
               end
            BANK_ACTIVATING:
               if (timer == '0)
                  o_state <= BANK_ACTIVE;
            BANK_ACTIVE, BANK_READ, BANK_WRITE:
               if (i_column)
                  o_state <= col_state;
               else if (i_precharge)
               begin
                  o_state <= BANK_PRECHARGING;
                  timer <= PRECHARGE_CYCLES - 2'h2;
               end
               else if (i_burst_stop)
                  o_state <= BANK_ACTIVE;
            BANK_READ_AP:
               if (i_burst_stop)
               begin
                  o_state <= BANK_AP_PRECHARGE;
                  timer <= PRECHARGE_CYCLES - 2'h2;
               end
            BANK_WRITE_AP:
               if (i_burst_stop)
               begin
                  o_state <= BANK_AP_RECOVERY;
                  timer <= WRITE_RECOVERY_CYCLES - 2'h1;
               end
            BANK_AP_RECOVERY:
               if (timer == '0)
               begin
                  o_state <= BANK_AP_PRECHARGE;
                  timer <= PRECHARGE_CYCLES - 2'h2;
               end
            BANK_PRECHARGING, BANK_AP_PRECHARGE:
               if (timer == '0)
                  o_state <= BANK_IDLE;
            default:
               o_state <= BANK_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         o_row <= '0;
      else if (i_activate && o_state == BANK_IDLE)
         o_row <= i_row;
   end
endmodule
`default_nettype wire

/* sdram_cross_bank.sv */
// Four-bank SDRAM core: command decode, cross-bank acceptance, burst
// engine, read pipeline and a small storage array.
// Assumes command and data pins are synchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none
module sdram_cross_bank
   import sdram_bank_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int MEM_ROW_W = 2,
   parameter int COL_W = 10
)
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_cke,
   input wire sdram_cmd_type i_cmd,
   input wire logic i_dqm,
   input wire logic [DATA_W-1:0] i_dq,
   output logic [DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   output var bank_state_type [NUM_BANKS-1:0] o_bank_state,
   output logic o_all_idle,
   output logic o_self_refresh,
   output logic o_cmd_error
);
   localparam int MEM_AW = BANK_W + MEM_ROW_W + COL_W;

   if (COL_W < 3 || COL_W > AUTO_PRE_BIT || MEM_ROW_W < 1 || MEM_ROW_W > ADDR_W
       || DATA_W < 1)
   begin : g_check
      $error("unsupported array geometry");
   end

   logic [DATA_W-1:0] mem [0:(1 << MEM_AW)-1];
   cmd_kind_type kind;
   logic cke_prev;
   logic [TIMER_W-1:0] busy_cnt;
   logic busy;
   logic cmd_window;
   logic [2:0] bl_code;
   logic [2:0] read_latency;
   logic [COL_W-1:0] burst_mask;
   logic continuous;
   logic burst_on;
   logic [BANK_W-1:0] burst_bank;
   logic burst_wr;
   logic [COL_W-1:0] col;
   logic [COL_W-1:0] left;
   logic acc_act;
   logic acc_col;
   logic acc_pre;
   logic acc_bst;
   logic acc_ar;
   logic acc_lmr;
   logic enter_self_ref;
   logic any_cmd;
   logic all_pre_ok;
   logic owner_pre;
   logic natural_end;
   logic engine_stop;
   logic word_act;
   logic word_wr;
   logic [BANK_W-1:0] word_bank;
   logic [COL_W-1:0] word_col;
   logic [COL_W-1:0] next_col;
   logic [MEM_AW-1:0] word_addr;
   logic [DATA_W-1:0] stage0;
   logic [DATA_W-1:0] stage1;
   logic valid0;
   logic valid1;
   logic dqm_d1;
   logic wr_start;
   logic [NUM_BANKS-1:0] bank_act;
   logic [NUM_BANKS-1:0] bank_col;
   logic [NUM_BANKS-1:0] bank_pre;
   logic [NUM_BANKS-1:0] bank_stop;
   logic [ADDR_W-1:0] bank_row [NUM_BANKS];
   bank_state_type tgt;
   bank_state_type owner;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   always_comb
   begin
      kind = CMD_NOP;
      if (!i_cmd.cs_n)
      begin
         case ({i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n})
            3'h3: kind = CMD_ACT;
            3'h5: kind = CMD_RD;
            3'h4: kind = CMD_WR;
            3'h6: kind = CMD_BST;
            3'h2: kind = CMD_PRE;
            3'h1: kind = CMD_AR;
            3'h0: kind = CMD_LMR;
            default: kind = CMD_NOP;
         endcase
      end
   end

   assign busy = (busy_cnt != '0);
   assign cmd_window = cke_prev && i_cke && !busy && !o_self_refresh;
   assign any_cmd = cke_prev && i_cke && (kind != CMD_NOP);
   assign tgt = o_bank_state[i_cmd.ba];
   assign owner = o_bank_state[burst_bank];

   // ---------------------------------------------------------------
   // Acceptance against the target bank's state, or every bank's for precharge all, refresh and mode load
   // ---------------------------------------------------------------
   always_comb
   begin
      all_pre_ok = 1'b1;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         if (!(o_bank_state[b] inside {BANK_IDLE, BANK_ACTIVE, BANK_READ, BANK_WRITE}))
            all_pre_ok = 1'b0;
      end
   end

   always_comb
   begin
      acc_act = cmd_window && kind == CMD_ACT && tgt == BANK_IDLE;
      acc_col = cmd_window && (kind == CMD_RD || kind == CMD_WR)
                && (tgt inside {BANK_ACTIVE, BANK_READ, BANK_WRITE});
      acc_pre = cmd_window && kind == CMD_PRE
                && (i_cmd.addr[AUTO_PRE_BIT] ? all_pre_ok
                    : (tgt inside {BANK_IDLE, BANK_ACTIVE, BANK_READ, BANK_WRITE}));
      acc_bst = cmd_window && kind == CMD_BST && burst_on
                && burst_bank == i_cmd.ba
                && (owner inside {BANK_READ, BANK_WRITE});
      acc_ar = cmd_window && kind == CMD_AR && o_all_idle;
      acc_lmr = cmd_window && kind == CMD_LMR && o_all_idle
                && (i_cmd.addr[BL_LSB +: 3] inside {3'h0, 3'h1, 3'h2, 3'h3, BL_CODE_FULL})
                && (i_cmd.addr[CL_LSB +: 3] inside {3'h2, 3'h3});
      enter_self_ref = cke_prev && !i_cke && !busy && !o_self_refresh
                       && kind == CMD_AR && o_all_idle;
   end

   always_comb
   begin
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         bank_act[b] = acc_act && i_cmd.ba == BANK_W'(b);
         bank_col[b] = acc_col && i_cmd.ba == BANK_W'(b);
         bank_pre[b] = acc_pre && (i_cmd.addr[AUTO_PRE_BIT] || i_cmd.ba == BANK_W'(b));
      end
   end

   // ---------------------------------------------------------------
   // Bank state machines
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NUM_BANKS; g++)
   begin : g_bank
      sdram_bank_tracker #(
         .ROW_W(ADDR_W)
      ) u_bank (
         .i_mclk(i_mclk),
         .i_reset_n(i_reset_n),
         .i_activate(bank_act[g]),
         .i_column(bank_col[g]),
         .i_write(kind == CMD_WR),
         .i_auto_pre(i_cmd.addr[AUTO_PRE_BIT]),
         .i_precharge(bank_pre[g]),
         .i_burst_stop(bank_stop[g]),
         .i_row(i_cmd.addr),
         .o_state(o_bank_state[g]),
         .o_row(bank_row[g])
      );
   end

   always_comb
   begin
      o_all_idle = 1'b1;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         if (o_bank_state[b] != BANK_IDLE)
            o_all_idle = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Mode, clock enable and global busy time
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         bl_code <= RESET_BL_CODE;
         read_latency <= RESET_READ_LATENCY;
      end
      else if (acc_lmr)
      begin
         bl_code <= i_cmd.addr[BL_LSB +: 3];
         read_latency <= i_cmd.addr[CL_LSB +: 3];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         cke_prev <= 1'b0;
      else
         cke_prev <= i_cke;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_self_refresh <= 1'b0;
         busy_cnt <= '0;
      end
      else if (o_self_refresh)
      begin
         if (i_cke)
         begin
            o_self_refresh <= 1'b0;
            busy_cnt <= SELF_REFRESH_EXIT_CYCLES - 1'b1;
         end
      end
      else if (enter_self_ref)
         o_self_refresh <= 1'b1;
      else if (acc_ar)
         busy_cnt <= AUTO_REFRESH_CYCLES - 1'b1;
      else if (busy)
         busy_cnt <= busy_cnt - 1'b1;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         o_cmd_error <= 1'b0;
      else
         o_cmd_error <= any_cmd && !(acc_act || acc_col || acc_pre || acc_bst
                                    || acc_ar || acc_lmr);
   end

   // ---------------------------------------------------------------
   // Burst engine
   // ---------------------------------------------------------------
   always_comb
   begin
      case (bl_code)
         3'h0: burst_mask = COL_W'(0);
         3'h1: burst_mask = COL_W'(1);
         3'h2: burst_mask = COL_W'(3);
         3'h3: burst_mask = COL_W'(7);
         default: burst_mask = '1;
      endcase
      continuous = (bl_code == BL_CODE_FULL);
   end

   assign owner_pre = acc_pre && bank_pre[burst_bank];
   assign natural_end = burst_on && !continuous && left == '0;
   assign engine_stop = acc_bst || owner_pre || natural_end;
   assign word_act = acc_col || (burst_on && !engine_stop);
   assign word_wr = acc_col ? (kind == CMD_WR) : burst_wr;
   assign word_bank = acc_col ? i_cmd.ba : burst_bank;
   assign word_col = acc_col ? i_cmd.addr[COL_W-1:0] : col;
   assign next_col = (word_col & ~burst_mask) | ((word_col + 1'b1) & burst_mask);
   assign word_addr = {word_bank, bank_row[word_bank][MEM_ROW_W-1:0], word_col};
   assign wr_start = acc_col && kind == CMD_WR;

   always_comb
   begin
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         bank_stop[b] = burst_on && burst_bank == BANK_W'(b)
                        && ((acc_col && i_cmd.ba != burst_bank)
                            || acc_bst
                            || (natural_end && !acc_col));
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         burst_on <= 1'b0;
         burst_bank <= '0;
         burst_wr <= 1'b0;
         col <= '0;
         left <= '0;
      end
      else if (acc_col)
      begin
         burst_on <= 1'b1;
         burst_bank <= i_cmd.ba;
         burst_wr <= (kind == CMD_WR);
         col <= next_col;
         left <= burst_mask;
      end
      else if (engine_stop)
         burst_on <= 1'b0;
      else if (burst_on)
      begin
         col <= next_col;
         left <= continuous ? left : left - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Storage and read pipeline
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (word_act && word_wr && !i_dqm)
         mem[word_addr] <= i_dq;
   end

   always_ff @(posedge i_mclk)
   begin
      stage0 <= mem[word_addr];
      stage1 <= stage0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         valid0 <= 1'b0;
         valid1 <= 1'b0;
         dqm_d1 <= 1'b0;
      end
      else
      begin
         valid0 <= word_act && !word_wr;
         valid1 <= valid0 && !wr_start;
         dqm_d1 <= i_dqm;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         o_dq <= '0;
         o_dq_oe <= 1'b0;
      end
      else if (read_latency == 3'h3)
      begin
         o_dq <= stage1;
         o_dq_oe <= valid1 && !dqm_d1 && !wr_start;
      end
      else
      begin
         o_dq <= stage0;
         o_dq_oe <= valid0 && !dqm_d1 && !wr_start;
      end
   end
endmodule
`default_nettype wire

/* sdram_cross_bank_props.sv */
// Port assertions for the four-bank SDRAM core.
// Assumes one clock and a synchronous active-low reset held 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module sdram_cross_bank_props
   import sdram_bank_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_cke,
   input wire sdram_cmd_type i_cmd,
   input wire logic o_dq_oe,
   input wire bank_state_type [NUM_BANKS-1:0] o_bank_state,
   input wire logic o_all_idle,
   input wire logic o_cmd_error
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic cke_q;
   logic live;
   logic is_act;
   logic is_col;
   logic is_bst;
   bank_state_type tgt;
   always_ff @(posedge i_mclk)
   begin
      cke_q <= i_reset_n ? i_cke : 1'b0;
   end
   assign live = i_cke && cke_q && !i_cmd.cs_n;
   assign is_act = live && !i_cmd.ras_n && i_cmd.cas_n && i_cmd.we_n;
   assign is_col = live && i_cmd.ras_n && !i_cmd.cas_n;
   assign is_bst = live && i_cmd.ras_n && i_cmd.cas_n && !i_cmd.we_n;
   assign tgt = o_bank_state[i_cmd.ba];
   property p_inhibit;
      i_cmd.cs_n |=> !o_cmd_error;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("error flag after inhibit");
   property p_cke_low;
      !i_cke |=> !o_cmd_error;
   endproperty
   a_cke_low: assert property (p_cke_low) else $error("error flag with cke low");
   property p_other_act;
      is_act && tgt == BANK_IDLE && !o_all_idle
         |=> o_bank_state[$past(i_cmd.ba)] == BANK_ACTIVATING && !o_cmd_error;
   endproperty
   a_other_act: assert property (p_other_act) else $error("activate refused");
   property p_col_kind;
      is_col && tgt == BANK_ACTIVE |=> o_bank_state[$past(i_cmd.ba)] ==
         ($past(i_cmd.addr[AUTO_PRE_BIT]) ?
         ($past(i_cmd.we_n) ? BANK_READ_AP : BANK_WRITE_AP) :
         ($past(i_cmd.we_n) ? BANK_READ : BANK_WRITE));
   endproperty
   a_col_kind: assert property (p_col_kind) else $error("wrong burst state");
   property p_wr_quiet;
      is_col && !i_cmd.we_n && tgt inside {BANK_ACTIVE, BANK_READ, BANK_WRITE}
         |=> !o_dq_oe [*2];
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("output on after write");
   property p_bst_other;
      is_bst && !(tgt inside {BANK_READ, BANK_WRITE}) |=> o_cmd_error;
   endproperty
   a_bst_other: assert property (p_bst_other) else $error("stray stop taken");
   for (genvar b = 0; b < NUM_BANKS; b++)
   begin : g_bank
      property p_pre_len;
         o_bank_state[b] == BANK_IDLE &&
            $past(o_bank_state[b]) inside {BANK_PRECHARGING, BANK_AP_PRECHARGE}
            |-> $past(o_bank_state[b], 2) == $past(o_bank_state[b]) &&
            $past(o_bank_state[b], 3) == $past(o_bank_state[b]);
      endproperty
      a_pre_len: assert property (p_pre_len) else $error("precharge too short");
      property p_rd_ap_cut;
         o_bank_state[b] == BANK_READ_AP && is_col && i_cmd.ba != BANK_W'(b) &&
            tgt inside {BANK_ACTIVE, BANK_READ, BANK_WRITE}
            |=> o_bank_state[b] == BANK_AP_PRECHARGE;
      endproperty
      a_rd_ap_cut: assert property (p_rd_ap_cut) else $error("no precharge on cut");
      property p_wr_ap_cut;
         o_bank_state[b] == BANK_WRITE_AP && is_col && i_cmd.ba != BANK_W'(b) &&
            tgt inside {BANK_ACTIVE, BANK_READ, BANK_WRITE}
            |=> (o_bank_state[b] == BANK_AP_RECOVERY) [*3] ##1
            o_bank_state[b] == BANK_AP_PRECHARGE;
      endproperty
      a_wr_ap_cut: assert property (p_wr_ap_cut) else $error("bad write recovery");
   end
   c_act: cover property (is_act && !o_all_idle);
   c_rd_cut: cover property (o_bank_state[0] == BANK_AP_PRECHARGE);
   c_wr_cut: cover property (o_bank_state[3] == BANK_AP_RECOVERY);
endmodule
bind sdram_cross_bank sdram_cross_bank_props u_props (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
   .i_cke(i_cke), .i_cmd(i_cmd), .o_dq_oe(o_dq_oe), .o_bank_state(o_bank_state),
   .o_all_idle(o_all_idle), .o_cmd_error(o_cmd_error));
`default_nettype wire

/* sdram_cross_bank_test.sv */
// Self-checking bench for the four-bank SDRAM core.
// Assumes the controller model drives all command pins.
`timescale 1ns/1ps
`default_nettype none
module sdram_cross_bank_test;
   import sdram_bank_pkg::*;
   typedef struct {
      cmd_kind_type k;
      logic [1:0] b;
      logic [12:0] a;
      bank_state_type s;
      logic e;
      int w;
   } row_type;
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic cke;
   sdram_cmd_type cmd;
   logic dqm;
   logic [15:0] dq;
   logic [15:0] o_dq;
   logic o_dq_oe;
   bank_state_type [NUM_BANKS-1:0] o_bank_state;
   logic o_all_idle;
   logic o_self_refresh;
   logic o_cmd_error;
   int n_fail = 0;
   int n_compared = 0;
   row_type rows [7] = '{
      '{CMD_LMR, 2'h0, 13'h0022, BANK_IDLE, 1'b0, 2},
      '{CMD_ACT, 2'h0, 13'h1235, BANK_ACTIVATING, 1'b0, 0},
      '{CMD_ACT, 2'h1, 13'h0A06, BANK_ACTIVATING, 1'b0, 0},
      '{CMD_RD, 2'h1, 13'h0000, BANK_ACTIVATING, 1'b1, 0},
      '{CMD_AR, 2'h0, 13'h0000, BANK_ACTIVE, 1'b1, 0},
      '{CMD_PRE, 2'h2, 13'h0000, BANK_IDLE, 1'b0, 0},
      '{CMD_BST, 2'h2, 13'h0000, BANK_IDLE, 1'b1, 3}};
   always #2.5 i_mclk = ~i_mclk;
   sdram_ctrl_model u_ctrl (.i_mclk(i_mclk), .o_cke(cke), .o_cmd(cmd), .o_dqm(dqm), .o_dq(dq));
   sdram_cross_bank u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cke(cke), .i_cmd(cmd),
      .i_dqm(dqm), .i_dq(dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_bank_state(o_bank_state),
      .o_all_idle(o_all_idle), .o_self_refresh(o_self_refresh), .o_cmd_error(o_cmd_error));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [1:0] b, input logic [12:0] a, input logic [15:0] d, input int n);
      u_ctrl.issue(CMD_WR, b, a, d, 1'b0);
      for (int i = 1; i < n; i++)
         u_ctrl.issue(CMD_NOP, b, a, d + 16'(i), 1'b0);
   endtask
   task automatic rd2(input logic [1:0] b, input logic [12:0] a, input cmd_kind_type k2,
      input logic [1:0] b2, input logic [15:0] e [4]);
      u_ctrl.issue(CMD_RD, b, a, 16'h0000, 1'b0);
      u_ctrl.issue(k2, b2, 13'h0000, 16'h0000, 1'b0);
      u_ctrl.idle(1);
      for (int i = 0; i < 4; i++)
      begin
         check("read word", o_dq, e[i]);
         check("read enable", 16'(o_dq_oe), 16'h0001);
         @(negedge i_mclk);
      end
   endtask
   task automatic wait_idle(input int b);
      int c;
      c = 0;
      while (o_bank_state[b] !== BANK_IDLE && c < 12)
      begin
         @(negedge i_mclk);
         c++;
      end
      check("bank idle", 16'(o_bank_state[b]), 16'(BANK_IDLE));
      if (c == 12)
         conclude();
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(negedge i_mclk);
      i_reset_n = 1'b1;
      u_ctrl.idle(3);
      foreach (rows[i])
      begin
         u_ctrl.issue(rows[i].k, rows[i].b, rows[i].a, 16'h0000, 1'b0);
         u_ctrl.idle(1);
         check("bank state", 16'(o_bank_state[rows[i].b]), 16'(rows[i].s));
         check("cmd error", 16'(o_cmd_error), 16'(rows[i].e));
         u_ctrl.idle(rows[i].w);
      end
      $display("done table");
      wr(2'h0, 13'h0000, 16'hA000, 4);
      wr(2'h1, 13'h0000, 16'hC000, 4);
      wr(2'h0, 13'h0000, 16'hF000, 2);
      rd2(2'h1, 13'h0001, CMD_NOP, 2'h1, '{16'hC001, 16'hC002, 16'hC003, 16'hC000});
      rd2(2'h0, 13'h0000, CMD_RD, 2'h1, '{16'hF000, 16'hC000, 16'hC001, 16'hC002});
      rd2(2'h0, 13'h0000, CMD_PRE, 2'h1, '{16'hF000, 16'hF001, 16'hA002, 16'hA003});
      $display("done interrupts");
      u_ctrl.issue(CMD_ACT, 2'h2, 13'h0003, 16'h0000, 1'b0);
      u_ctrl.issue(CMD_ACT, 2'h3, 13'h1FFC, 16'h0000, 1'b0);
      u_ctrl.idle(4);
      u_ctrl.issue(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 1'b1);
      u_ctrl.issue(CMD_RD, 2'h0, 13'h0400, 16'h0000, 1'b1);
      wr(2'h2, 13'h0000, 16'h5000, 1);
      u_ctrl.issue(CMD_NOP, 2'h2, 13'h0000, 16'h5001, 1'b0);
      check("precharge start", 16'(o_bank_state[0]), 16'(BANK_AP_PRECHARGE));
      check("output enable", 16'(o_dq_oe), 16'h0000);
      u_ctrl.issue(CMD_NOP, 2'h2, 13'h0000, 16'h5002, 1'b0);
      u_ctrl.issue(CMD_NOP, 2'h2, 13'h0000, 16'h5003, 1'b0);
      u_ctrl.idle(1);
      wait_idle(0);
      wr(2'h3, 13'h0404, 16'h7000, 2);
      rd2(2'h2, 13'h0000, CMD_NOP, 2'h2, '{16'h5000, 16'h5001, 16'h5002, 16'h5003});
      wait_idle(3);
      $display("done auto precharge");
      u_ctrl.set_cke(1'b0);
      u_ctrl.issue(CMD_ACT, 2'h1, 13'h0A06, 16'h0000, 1'b0);
      u_ctrl.idle(1);
      check("blocked act", 16'(o_bank_state[1]), 16'(BANK_IDLE));
      check("blocked error", 16'(o_cmd_error), 16'h0000);
      check("no self refresh", 16'(o_self_refresh), 16'h0000);
      u_ctrl.set_cke(1'b1);
      u_ctrl.issue(CMD_ACT, 2'h1, 13'h0A06, 16'h0000, 1'b0);
      u_ctrl.idle(1);
      i_reset_n = 1'b0;
      u_ctrl.idle(3);
      check("reset idle", 16'(o_all_idle), 16'h0001);
      i_reset_n = 1'b1;
      u_ctrl.idle(2);
      u_ctrl.issue(CMD_ACT, 2'h1, 13'h0A06, 16'h0000, 1'b0);
      u_ctrl.idle(1);
      check("act after reset", 16'(o_bank_state[1]), 16'(BANK_ACTIVATING));
      u_ctrl.idle(2);
      u_ctrl.issue(CMD_RD, 2'h1, 13'h0000, 16'h0000, 1'b0);
      u_ctrl.idle(2);
      check("latency gap", 16'(o_dq_oe), 16'h0000);
      u_ctrl.idle(1);
      check("latency three", o_dq, 16'hC000);
      $display("done reset");
      conclude();
   end
endmodule
`default_nettype wire

/* sdram_ctrl_model.sv */
// Memory controller model driving command, mask and data pins.
// Assumes callers issue one command per falling edge, then idle.
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
   import sdram_bank_pkg::*;
(
   input wire logic i_mclk,
   output var logic o_cke,
   output var sdram_cmd_type o_cmd,
   output var logic o_dqm,
   output var logic [15:0] o_dq
);
   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h6, 3'h2, 3'h1, 3'h0};
   initial
   begin
      o_cke = 1'b1;
      o_cmd = '1;
      o_dqm = 1'b0;
      o_dq = 16'h0000;
   end
   task automatic issue(input cmd_kind_type k, input logic [1:0] b, input logic [12:0] a,
      input logic [15:0] d, input logic m);
      @(negedge i_mclk);
      o_cmd = {1'b0, ENC[k], b, a};
      o_dqm = m;
      o_dq = d;
   endtask
   task automatic idle(input int n);
      repeat (n)
      begin
         @(negedge i_mclk);
         o_cmd.cs_n = 1'b1;
         o_dqm = 1'b0;
         o_dq = ~o_dq;
      end
   endtask
   task automatic set_cke(input logic v);
      @(negedge i_mclk);
      o_cke = v;
   endtask
endmodule
`default_nettype wire
